/* File: switch_array_consts.svh */
// Constants for the switch array control block
`ifndef SWITCH_ARRAY_CONSTS_SVH
`define SWITCH_ARRAY_CONSTS_SVH

`define SA_CHANNELS 32
`define SA_TEMP_W 8
`define SA_ADDR_W 32
`define SA_DATA_W 32
`define SA_OFF_W 8

// Register byte offsets
`define SA_OFF_TEMP_CFG 8'h00
`define SA_OFF_SHIFT 8'h04
`define SA_OFF_LATCH 8'h08
`define SA_OFF_STATUS 8'h0c

// Register index codes from the decode function
`define SA_IDX_TEMP_CFG 3'h0
`define SA_IDX_SHIFT 3'h1
`define SA_IDX_LATCH 3'h2
`define SA_IDX_STATUS 3'h3
`define SA_IDX_NONE 3'h7

// Field positions
`define SA_TRIP_LSB 0
`define SA_HYST_LSB 8
`define SA_ST_OVERTEMP 0
`define SA_ST_BANK 1
`define SA_ST_SOUT 2

// Reset values, degrees C
`define SA_TRIP_RST 8'h6e
`define SA_HYST_RST 8'h0a

`endif

/* File: switch_array_pkg.sv */
// Types shared by the switch array control block
`default_nettype none
package switch_array_pkg;

	// Control pins, grouped for synchronising
	typedef struct packed {
		logic serial_clk;
		logic serial_data;
		logic latch_enable_n;
		logic clear_in;
		logic bank_en;
	} ctrl_pins_t;

endpackage
`default_nettype wire

/* File: switch_array_serial_latch_control.sv */
// Switch array serial/bank latch control with AHB-Lite status and thermal flag
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "switch_array_consts.svh"

module switch_array_serial_latch_control
	import switch_array_pkg::*;
#(
	parameter int CHANNELS = `SA_CHANNELS,
	parameter int TEMP_W = `SA_TEMP_W
)
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	// Control pins from the external controller
	input wire logic serial_clk_i,
	input wire logic serial_ctrl_interface_i,
	input wire logic latch_enable_n_i,
	input wire logic clear_in_i,
	input wire logic bank_en_i,
	// Die temperature from the on-chip sensor, core clock domain
	input wire logic [TEMP_W-1:0] die_temp_i,
	// Switch drive and serial chain
	output logic [CHANNELS-1:0] channel_o,
	output logic serial_out_o,
	// Open-drain thermal flag
	output logic overtemp_flag_n_o,
	output logic overtemp_flag_n_oe_o,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [`SA_ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [`SA_DATA_W-1:0] hwdata_i,
	output logic [`SA_DATA_W-1:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);

	function automatic logic [2:0] reg_index(input logic [`SA_ADDR_W-1:0] addr);
		logic [2:0] idx;
		idx = `SA_IDX_NONE;
		if (addr[`SA_ADDR_W-1:`SA_OFF_W] == '0)
		begin
			unique case (addr[`SA_OFF_W-1:0])
				`SA_OFF_TEMP_CFG: idx = `SA_IDX_TEMP_CFG;
				`SA_OFF_SHIFT: idx = `SA_IDX_SHIFT;
				`SA_OFF_LATCH: idx = `SA_IDX_LATCH;
				`SA_OFF_STATUS: idx = `SA_IDX_STATUS;
				default: idx = `SA_IDX_NONE;
			endcase
		end
		return idx;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and serial clock edge
	// ----------------------------------------------------------------
	ctrl_pins_t pins_raw;
	ctrl_pins_t sync1_r, sync2_r, sync1_nxt, sync2_nxt;
	logic sclk_prev_r, sclk_prev_nxt;
	logic sclk_rise;

	assign pins_raw = '{serial_clk: serial_clk_i, serial_data: serial_ctrl_interface_i,
		latch_enable_n: latch_enable_n_i, clear_in: clear_in_i, bank_en: bank_en_i};

	always_comb
	begin
		sync1_nxt = pins_raw;
		sync2_nxt = sync1_r;
		sclk_prev_nxt = sync2_r.serial_clk;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			sclk_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			sclk_prev_r <= sclk_prev_nxt;
		end
	end

	assign sclk_rise = sync2_r.serial_clk & ~sclk_prev_r;

	// ----------------------------------------------------------------
	// Shift register, latch and channel drive
	// ----------------------------------------------------------------
	logic [CHANNELS-1:0] shift_r, shift_nxt, latch_r, latch_nxt, channel_nxt;
	logic serial_mode;

	assign serial_mode = ~sync2_r.bank_en;

	always_comb
	begin
		shift_nxt = shift_r;
		latch_nxt = latch_r;
		if (serial_mode && sync2_r.clear_in)
		begin
			shift_nxt = '0;
			latch_nxt = '0;
		end
		else if (serial_mode)
		begin
			if (sclk_rise)
				shift_nxt = {shift_r[CHANNELS-2:0], sync2_r.serial_data};
			if (!sync2_r.latch_enable_n)
				latch_nxt = shift_nxt;
		end
		if (serial_mode)
			channel_nxt = latch_nxt;
		else
			channel_nxt = {CHANNELS{sync2_r.serial_data}};
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			shift_r <= '0;
			latch_r <= '0;
			channel_o <= '0;
			serial_out_o <= 1'b0;
		end
		else
		begin
			shift_r <= shift_nxt;
			latch_r <= latch_nxt;
			channel_o <= channel_nxt;
			serial_out_o <= shift_nxt[CHANNELS-1];
		end
	end

	// ----------------------------------------------------------------
	// Thermal flag with hysteresis
	// ----------------------------------------------------------------
	logic [TEMP_W-1:0] trip_r, trip_nxt, hyst_r, hyst_nxt;
	logic hot_r, hot_nxt;
	logic [TEMP_W:0] temp_plus_hyst;

	assign temp_plus_hyst = {1'b0, die_temp_i} + {1'b0, hyst_r};

	always_comb
	begin
		hot_nxt = hot_r;
		if (die_temp_i > trip_r)
			hot_nxt = 1'b1;
		else if (temp_plus_hyst <= {1'b0, trip_r})
			hot_nxt = 1'b0;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			hot_r <= 1'b0;
			overtemp_flag_n_o <= 1'b0;
			overtemp_flag_n_oe_o <= 1'b0;
		end
		else
		begin
			hot_r <= hot_nxt;
			overtemp_flag_n_o <= 1'b0;
			overtemp_flag_n_oe_o <= hot_nxt;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite register slave, zero wait states
	// ----------------------------------------------------------------
	logic addr_ok;
	logic wr_pend_r, wr_pend_nxt;
	logic [2:0] wr_idx_r, wr_idx_nxt, rd_idx;
	logic [`SA_DATA_W-1:0] rdata_nxt;

	assign addr_ok = hsel_i & hready_i & htrans_i[1];
	assign rd_idx = reg_index(haddr_i);

	always_comb
	begin
		wr_pend_nxt = addr_ok & hwrite_i;
		wr_idx_nxt = reg_index(haddr_i);
		trip_nxt = trip_r;
		hyst_nxt = hyst_r;
		if (wr_pend_r && wr_idx_r == `SA_IDX_TEMP_CFG)
		begin
			trip_nxt = hwdata_i[`SA_TRIP_LSB +: TEMP_W];
			hyst_nxt = hwdata_i[`SA_HYST_LSB +: TEMP_W];
		end
		rdata_nxt = '0;
		if (addr_ok && !hwrite_i)
		begin
			unique case (rd_idx)
				`SA_IDX_TEMP_CFG:
				begin
					rdata_nxt[`SA_TRIP_LSB +: TEMP_W] = trip_r;
					rdata_nxt[`SA_HYST_LSB +: TEMP_W] = hyst_r;
				end
				`SA_IDX_SHIFT: rdata_nxt[CHANNELS-1:0] = shift_r;
				`SA_IDX_LATCH: rdata_nxt[CHANNELS-1:0] = latch_r;
				`SA_IDX_STATUS:
				begin
					rdata_nxt[`SA_ST_OVERTEMP] = hot_r;
					rdata_nxt[`SA_ST_BANK] = sync2_r.bank_en;
					rdata_nxt[`SA_ST_SOUT] = shift_r[CHANNELS-1];
				end
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_pend_r <= 1'b0;
			wr_idx_r <= `SA_IDX_NONE;
			trip_r <= `SA_TRIP_RST;
			hyst_r <= `SA_HYST_RST;
			hrdata_o <= '0;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			wr_pend_r <= wr_pend_nxt;
			wr_idx_r <= wr_idx_nxt;
			trip_r <= trip_nxt;
			hyst_r <= hyst_nxt;
			hrdata_o <= rdata_nxt;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	bank_drive_a: assert property (sync2_r.bank_en |=>
		channel_o == {CHANNELS{$past(sync2_r.serial_data)}})
		else $error("bank mode channels differ from bank data");
	serial_drive_a: assert property (!sync2_r.bank_en |=> channel_o == latch_r)
		else $error("serial mode channels differ from latch");
	latch_hold_a: assert property (serial_mode && sync2_r.latch_enable_n
		&& !sync2_r.clear_in |=> $stable(latch_r))
		else $error("latch changed while held");
	latch_pass_a: assert property (serial_mode && !sync2_r.latch_enable_n
		&& !sync2_r.clear_in |=> latch_r == shift_r)
		else $error("open latch does not follow shift register");
	clear_empty_a: assert property (serial_mode && sync2_r.clear_in |=>
		shift_r == '0 && latch_r == '0)
		else $error("clear did not empty registers");
	shift_step_a: assert property (serial_mode && !sync2_r.clear_in && sclk_rise |=>
		shift_r == {$past(shift_r[CHANNELS-2:0]), $past(sync2_r.serial_data)})
		else $error("shift register did not advance");
	shift_idle_a: assert property (serial_mode && !sync2_r.clear_in && !sclk_rise |=>
		$stable(shift_r))
		else $error("shift register moved without clock edge");
	chain_out_a: assert property (serial_out_o == shift_r[CHANNELS-1])
		else $error("serial output not last stage");
	trip_flag_a: assert property (die_temp_i > trip_r |=>
		overtemp_flag_n_oe_o && !overtemp_flag_n_o)
		else $error("flag not pulled low above trip");
	hyst_keep_a: assert property (hot_r && temp_plus_hyst > {1'b0, trip_r} |=> hot_r)
		else $error("flag released inside hysteresis band");

	bank_all_on_c: cover property (sync2_r.bank_en && sync2_r.serial_data ##1 channel_o == '1);
	latch_load_c: cover property (sclk_rise ##1 !sync2_r.latch_enable_n ##1 latch_r != '0);
	trip_release_c: cover property (hot_r ##[1:50] !hot_r);

endmodule
`default_nettype wire

/* File: switch_ctrl_model.sv */
// Controller model driving the serial and bank pins
`timescale 1ns/100ps
`default_nettype none
module switch_ctrl_model
(
	input wire logic core_clk_i,
	output logic serial_clk_o,
	output logic data_o,
	output logic latch_enable_n_o,
	output logic clear_in_o,
	output logic bank_en_o
);
	initial
	begin
		serial_clk_o = 1'b0;
		data_o = 1'b0;
		latch_enable_n_o = 1'b1;
		clear_in_o = 1'b0;
		bank_en_o = 1'b0;
	end

	// Rest of 500 core clocks (10 us) after each pin change keeps switch toggling just under 50 kHz
	task automatic pins(input logic le_n, input logic clr, input logic bank, input logic d);
		@(posedge core_clk_i);
		latch_enable_n_o <= le_n;
		clear_in_o <= clr;
		bank_en_o <= bank;
		data_o <= d;
		repeat (500) @(posedge core_clk_i);
	endtask

	// Sends a word, bit 31 first; clock 5 cycles low, 4 high, idle low
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--)
		begin
			@(posedge core_clk_i);
			data_o <= w[i];
			repeat (4) @(posedge core_clk_i);
			serial_clk_o <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			serial_clk_o <= 1'b0;
		end
		repeat (6) @(posedge core_clk_i);
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the switch array control block
`timescale 1ns/100ps
`default_nettype none
`include "switch_array_consts.svh"
module testbench;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic sclk, sdat, le_n, clr, bank, sout, fl_n, fl_oe, hsel, hwrite, hready, hresp;
	logic [7:0] temp = 8'h19;
	logic [31:0] chan, haddr, hwdata, hrdata;
	logic [1:0] htrans;
	int num_errors = 0;
	int n_compared = 0;
	localparam logic [31:0] WA = 32'ha5c3_0f81;
	wire logic flag_pin = fl_oe ? fl_n : 1'b1;

	always #10 core_clk_i = ~core_clk_i;

	switch_ctrl_model ctl (.core_clk_i(core_clk_i), .serial_clk_o(sclk), .data_o(sdat),
		.latch_enable_n_o(le_n), .clear_in_o(clr), .bank_en_o(bank));

	switch_array_serial_latch_control dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.serial_clk_i(sclk), .serial_ctrl_interface_i(sdat), .latch_enable_n_i(le_n),
		.clear_in_i(clr), .bank_en_i(bank), .die_temp_i(temp), .channel_o(chan),
		.serial_out_o(sout), .overtemp_flag_n_o(fl_n), .overtemp_flag_n_oe_o(fl_oe),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp));

	task automatic wrap_up;
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk_i);
			n++;
		end
		while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1)
		begin
			num_errors++;
			wrap_up();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge core_clk_i);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(nm, d, exp);
	endtask

	task automatic temp_chk(input logic [7:0] t, input logic exp);
		@(posedge core_clk_i);
		temp <= t;
		repeat (3) @(posedge core_clk_i);
		chk("flag", {31'h0, flag_pin}, {31'h0, exp});
	endtask

	initial
	begin
		logic [31:0] d;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		repeat (5) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		@(posedge core_clk_i);
		chk("chan_rst", chan, 32'h0);
		ctl.pins(1'b1, 1'b0, 1'b0, 1'b0);
		ctl.send(WA);
		chk("chan_hold", chan, 32'h0);
		chk("sout", {31'h0, sout}, {31'h0, WA[31]});
		rd_chk("shift", `SA_OFF_SHIFT, WA);
		ctl.pins(1'b0, 1'b0, 1'b0, 1'b0);
		chk("chan_pass", chan, WA);
		rd_chk("latch", `SA_OFF_LATCH, WA);
		ctl.pins(1'b1, 1'b0, 1'b0, 1'b0);
		ctl.send(32'h0000_0001);
		chk("chan_keep", chan, WA);
		chk("sout0", {31'h0, sout}, 32'h0);
		ctl.pins(1'b0, 1'b1, 1'b0, 1'b0);
		chk("chan_clr", chan, 32'h0);
		rd_chk("shift_clr", `SA_OFF_SHIFT, 32'h0);
		ctl.pins(1'b0, 1'b1, 1'b1, 1'b1);
		chk("bank_on", chan, 32'hffff_ffff);
		rd_chk("status", `SA_OFF_STATUS, 32'h2);
		ctl.pins(1'b1, 1'b0, 1'b1, 1'b0);
		chk("bank_off", chan, 32'h0);
		ctl.pins(1'b0, 1'b0, 1'b0, 1'b0);
		temp_chk(8'h6e, 1'b1);
		temp_chk(8'h6f, 1'b0);
		temp_chk(8'h65, 1'b0);
		temp_chk(8'h64, 1'b1);
		ahb(1'b1, `SA_OFF_TEMP_CFG, 32'h0000_0550, d);
		rd_chk("temp_cfg", `SA_OFF_TEMP_CFG, 32'h0000_0550);
		rd_chk("unmapped", 8'h10, 32'h0);
		temp_chk(8'h51, 1'b0);
		temp_chk(8'h4b, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
